// ### pkg/crtp_cfg.svh
/*
 Constants of the converter rate timers and pulse-width output.
 Assumes inclusion by bare name from the package and the design.
*/
`ifndef CRTP_CFG_SVH
`define CRTP_CFG_SVH
`define CRTP_CLK_HZ 100000000
`define CRTP_DAC_HZ0 4000
`define CRTP_DAC_HZ1 10000
`define CRTP_DAC_HZ2 16000
`define CRTP_DAC_HZ3 64000
`define CRTP_ADC_HZ0 8000
`define CRTP_ADC_HZ1 16000
`define CRTP_ADC_HZ2 32000
`define CRTP_ADC_HZ3 64000
`define CRTP_ADC_HZ4 128000
`define CRTP_PWM_BITS 10
`define CRTP_ADC_BITS 8
`define CRTP_CNT_BITS 16
`define CRTP_FIFO_DEPTH 8
`define CRTP_CNT_RST 16'h0000
`define CRTP_CNT_ONE 16'h0001
`define CRTP_HI_RST 16'h0000
`define CRTP_ADC_RST 8'h00
`define CRTP_TMR_ADC 0
`define CRTP_TMR_DAC 1
`endif

// ### pkg/crtp_pkg.sv
/*
 Types of the converter rate timers and pulse-width output.
 Assumes crtp_cfg.svh is on the include path.
*/
`default_nettype none
`include "crtp_cfg.svh"
package crtp_pkg;
    typedef logic [`CRTP_CNT_BITS-1:0] crtp_cnt_t;
    typedef struct packed {
        logic [2:0] adc_sel;
        logic [1:0] dac_sel;
    } crtp_rate_s;
    typedef enum logic {
        PWM_IDLE = 1'b0,
        PWM_RUN = 1'b1
    } crtp_pwm_e;
endpackage
`default_nettype wire

// ### logic/crtp_top.sv
/*
 Sample-rate timers for the input and output converters, a sample
 FIFO and the 10-bit pulse-width output.
 Assumes one clock clk_i; the DSP side shares it, the converter
 result arrives from outside and is synchronised here.
*/
// Summary of operation
// [RL1] Output is PWM of a 10-bit sample
// [RL2] 1024 duty levels, 16 kHz default rate; no default here, rate_i.dac_sel picks it and code 0 gives 4 kHz
// [RL3] Output rate selectable: 4, 10, 16, 64 kHz
// [RL4] Input converter yields 8-bit results
// [RL5] Input rate selectable 8 to 128 kHz
// [RL6] Two free-running timers divide the clock
// [RL7] Both rates programmed independently
// [RL8] Timers trigger; converters mutually asynchronous
// [RL9] Terminal count reloads and pulses one cycle
// [RL10] Reset clears counts; output low until sample
`timescale 1ns/10ps
`default_nettype none
`include "crtp_cfg.svh"

// ------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------
module crtp_fifo #(
    parameter int unsigned W = `CRTP_PWM_BITS,
    parameter int unsigned DEPTH = `CRTP_FIFO_DEPTH
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Async reset
    input wire logic ce_i, // Clock enable
    input wire logic in_valid_i, // Write request
    output logic in_ready_o, // Space left
    input wire logic [W-1:0] in_data_i, // Write data
    output logic out_valid_o, // Data held
    input wire logic out_ready_i, // Read accept
    output logic [W-1:0] out_data_o // Read data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy, push, pop;

    always_comb begin
        push = in_valid_i && rdy_ff;
        pop = out_ready_i && (cnt_ff != '0);
        nxt_wr = push ? AW'((wr_ff + 1'b1) % DEPTH) : wr_ff;
        nxt_rd = pop ? AW'((rd_ff + 1'b1) % DEPTH) : rd_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        // Registered ready, so a full FIFO stalls the writer cleanly
        nxt_rdy = nxt_cnt != (AW+1)'(DEPTH);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b1;
        end else if (ce_i) begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem[wr_ff] <= in_data_i;
        end
    end

    assign in_ready_o = rdy_ff;
    assign out_valid_o = cnt_ff != '0;
    assign out_data_o = mem[rd_ff];
endmodule

// ------------------------------------------------------------
// Top
// ------------------------------------------------------------
module crtp_top
    import crtp_pkg::*;
#(
    parameter crtp_cnt_t DAC_DIV0 = crtp_cnt_t'(`CRTP_CLK_HZ / `CRTP_DAC_HZ0),
    parameter crtp_cnt_t DAC_DIV1 = crtp_cnt_t'(`CRTP_CLK_HZ / `CRTP_DAC_HZ1),
    parameter crtp_cnt_t DAC_DIV2 = crtp_cnt_t'(`CRTP_CLK_HZ / `CRTP_DAC_HZ2),
    parameter crtp_cnt_t DAC_DIV3 = crtp_cnt_t'(`CRTP_CLK_HZ / `CRTP_DAC_HZ3),
    parameter crtp_cnt_t ADC_DIV0 = crtp_cnt_t'(`CRTP_CLK_HZ / `CRTP_ADC_HZ0),
    parameter crtp_cnt_t ADC_DIV1 = crtp_cnt_t'(`CRTP_CLK_HZ / `CRTP_ADC_HZ1),
    parameter crtp_cnt_t ADC_DIV2 = crtp_cnt_t'(`CRTP_CLK_HZ / `CRTP_ADC_HZ2),
    parameter crtp_cnt_t ADC_DIV3 = crtp_cnt_t'(`CRTP_CLK_HZ / `CRTP_ADC_HZ3),
    parameter crtp_cnt_t ADC_DIV4 = crtp_cnt_t'(`CRTP_CLK_HZ / `CRTP_ADC_HZ4)
) (
    input wire logic clk_i, // Crystal clock
    input wire logic rst_i, // Async reset
    input wire logic ce_i, // Clock enable
    input wire crtp_rate_s rate_i, // Rate selects
    input wire logic smp_valid_i, // Sample offered
    output logic smp_ready_o, // FIFO space
    input wire logic [`CRTP_PWM_BITS-1:0] smp_data_i, // Sample
    input wire logic [`CRTP_ADC_BITS-1:0] adc_pin_i, // Converter code
    output logic adc_start_o, // Start conversion
    output logic adc_valid_o, // Result strobe
    output logic [`CRTP_ADC_BITS-1:0] adc_data_o, // Result
    output logic dac_trig_o, // Output sample tick
    output logic pwm_o // PWM pin
);
    // --------------------------------------------------------
    // Rate decode
    // --------------------------------------------------------
    // Codes 5..7 fall back to the fastest input rate
    function automatic crtp_cnt_t adc_div(input logic [2:0] sel);
        unique case (sel)
            3'h0: adc_div = ADC_DIV0;
            3'h1: adc_div = ADC_DIV1;
            3'h2: adc_div = ADC_DIV2;
            3'h3: adc_div = ADC_DIV3;
            default: adc_div = ADC_DIV4;
        endcase
    endfunction

    function automatic crtp_cnt_t dac_div(input logic [1:0] sel);
        unique case (sel)
            2'h0: dac_div = DAC_DIV0;
            2'h1: dac_div = DAC_DIV1;
            2'h2: dac_div = DAC_DIV2;
            2'h3: dac_div = DAC_DIV3;
        endcase
    endfunction

    crtp_cnt_t tdiv [2];
    crtp_cnt_t cnt_ff [2];
    crtp_cnt_t nxt_cnt [2];
    logic wrap [2];
    logic trig_ff [2];

    always_comb begin
        tdiv[`CRTP_TMR_ADC] = adc_div(rate_i.adc_sel); // RL5 RL7
        tdiv[`CRTP_TMR_DAC] = dac_div(rate_i.dac_sel); // RL3 RL7
    end

    // --------------------------------------------------------
    // Free-running rate timers
    // --------------------------------------------------------
    // Compare with >= so a shorter new period never overruns
    for (genvar i = 0; i < 2; i++) begin : g_tmr
        always_comb begin
            wrap[i] = cnt_ff[i] >= (tdiv[i] - `CRTP_CNT_ONE); // RL9
            nxt_cnt[i] = wrap[i] ? `CRTP_CNT_RST : cnt_ff[i] + `CRTP_CNT_ONE; // RL6
        end
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                cnt_ff[i] <= `CRTP_CNT_RST; // RL10
                trig_ff[i] <= 1'b0;
            end else if (ce_i) begin
                cnt_ff[i] <= nxt_cnt[i];
                trig_ff[i] <= wrap[i]; // RL8
            end
        end
    end

    // --------------------------------------------------------
    // Input converter capture
    // --------------------------------------------------------
    // Result sampled at a tick belongs to the previous conversion
    logic [`CRTP_ADC_BITS-1:0] sy1_ff, sy2_ff, adc_ff, nxt_adc;

    always_comb begin
        nxt_adc = wrap[`CRTP_TMR_ADC] ? sy2_ff : adc_ff; // RL4
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sy1_ff <= `CRTP_ADC_RST;
            sy2_ff <= `CRTP_ADC_RST;
            adc_ff <= `CRTP_ADC_RST;
        end else if (ce_i) begin
            sy1_ff <= adc_pin_i;
            sy2_ff <= sy1_ff;
            adc_ff <= nxt_adc;
        end
    end

    // --------------------------------------------------------
    // Pulse-width output
    // --------------------------------------------------------
    // Without a new sample at a tick the last duty repeats
    crtp_pwm_e st_ff, nxt_st;
    crtp_cnt_t hi_ff, nxt_hi;
    logic pwm_ff, nxt_pwm, fifo_vld, pop;
    logic [`CRTP_PWM_BITS-1:0] fifo_dat;
    logic [`CRTP_PWM_BITS+`CRTP_CNT_BITS-1:0] prod;

    crtp_fifo #(
        .W(`CRTP_PWM_BITS),
        .DEPTH(`CRTP_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_valid_i(smp_valid_i),
        .in_ready_o(smp_ready_o),
        .in_data_i(smp_data_i),
        .out_valid_o(fifo_vld),
        .out_ready_i(pop),
        .out_data_o(fifo_dat)
    );

    always_comb begin
        pop = wrap[`CRTP_TMR_DAC];
        // High time = sample / 1024 of the period
        prod = fifo_dat * tdiv[`CRTP_TMR_DAC]; // RL2
        nxt_st = st_ff;
        nxt_hi = hi_ff;
        unique case (st_ff)
            PWM_IDLE: begin
                if (pop && fifo_vld) begin
                    nxt_st = PWM_RUN; // RL10
                    nxt_hi = prod[`CRTP_PWM_BITS +: `CRTP_CNT_BITS]; // RL1
                end
            end
            PWM_RUN: begin
                if (pop && fifo_vld) begin
                    nxt_hi = prod[`CRTP_PWM_BITS +: `CRTP_CNT_BITS]; // RL1
                end
            end
        endcase
        nxt_pwm = (nxt_st == PWM_RUN) && (nxt_cnt[`CRTP_TMR_DAC] < nxt_hi); // RL1
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= PWM_IDLE;
            hi_ff <= `CRTP_HI_RST;
            pwm_ff <= 1'b0; // RL10
        end else if (ce_i) begin
            st_ff <= nxt_st;
            hi_ff <= nxt_hi;
            pwm_ff <= nxt_pwm;
        end
    end

    assign adc_start_o = trig_ff[`CRTP_TMR_ADC];
    assign adc_valid_o = trig_ff[`CRTP_TMR_ADC];
    assign adc_data_o = adc_ff;
    assign dac_trig_o = trig_ff[`CRTP_TMR_DAC];
    assign pwm_o = pwm_ff;

    // --------------------------------------------------------
    // Checks
    // --------------------------------------------------------
    // Checks hold only while the clock enable stays high
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || !ce_i);

    AST_PWM_IDLE_LOW: assert property ( // RL10
        st_ff == PWM_IDLE |-> !pwm_o
    ) else $error("PWM high before first sample");

    AST_RESET_CLEARS: assert property ( // RL10
        $past(rst_i) |-> cnt_ff[0] == '0 && cnt_ff[1] == '0
    ) else $error("Timer not cleared by reset");

    AST_DAC_PULSE: assert property ( // RL9
        dac_trig_o |=> !dac_trig_o
    ) else $error("Output tick longer than one cycle");

    AST_DAC_WRAP: assert property ( // RL6
        cnt_ff[1] == tdiv[1] - `CRTP_CNT_ONE |=> dac_trig_o && cnt_ff[1] == '0
    ) else $error("Output timer missed terminal count");

    AST_ADC_WRAP: assert property ( // RL8
        cnt_ff[0] == tdiv[0] - `CRTP_CNT_ONE |=> adc_start_o && cnt_ff[0] == '0
    ) else $error("Input timer missed terminal count");

    AST_INDEPENDENT: assert property ( // RL7
        cnt_ff[1] < tdiv[1] - `CRTP_CNT_ONE && $stable(rate_i.dac_sel)
        |=> cnt_ff[1] == $past(cnt_ff[1]) + `CRTP_CNT_ONE
    ) else $error("Output timer disturbed");

    AST_DUTY_START: assert property ( // RL1
        wrap[1] && fifo_vld |=> st_ff == PWM_RUN && pwm_o == (hi_ff != '0)
    ) else $error("Duty not started at tick");

    AST_DUTY_END: assert property ( // RL2
        st_ff == PWM_RUN && cnt_ff[1] >= hi_ff |-> !pwm_o
    ) else $error("PWM high past duty");

    AST_ADC_RESULT: assert property ( // RL4
        wrap[0] |=> adc_valid_o && adc_data_o == $past(sy2_ff)
    ) else $error("Result not captured at tick");

    COV_DAC_LOAD: cover property (wrap[1] && fifo_vld);
    COV_ADC_TICK: cover property (adc_valid_o);
    COV_FIFO_FULL: cover property (!smp_ready_o);
    COV_PWM_EDGE: cover property ($fell(pwm_o) && st_ff == PWM_RUN);
endmodule
`default_nettype wire

// ### testbench/crtp_ana_model.sv
/*
 Analogue side model: converter code source and PWM high-time meter.
 Assumes the block's pins on one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module crtp_ana_model (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Async reset
    input wire logic adc_start_i, // Conversion start
    input wire logic dac_trig_i, // Output period tick
    input wire logic pwm_i, // PWM pin
    output logic [7:0] adc_pin_o, // Converter code
    output logic [15:0] duty_o // High cycles of last period
);
    logic [15:0] hi_ff;
    // Code moves on after every start so stale captures show up
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            adc_pin_o <= 8'h5A;
            hi_ff <= 16'h0000;
            duty_o <= 16'h0000;
        end else begin
            if (adc_start_i) begin
                adc_pin_o <= adc_pin_o + 8'h25;
            end
            if (dac_trig_i) begin
                duty_o <= hi_ff;
                hi_ff <= {15'h0000, pwm_i};
            end else begin
                hi_ff <= hi_ff + {15'h0000, pwm_i};
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/test_crtp_top.sv
/*
 Self-checking bench of the rate timers, sample FIFO and PWM output.
 Assumes the package, the design and the analogue model compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_crtp_top;
    import crtp_pkg::*;
    typedef struct {logic [2:0] a; logic [1:0] d; int ap; int dp;} crtp_row_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic smp_valid_i = 1'b0;
    logic [9:0] smp_data_i = 10'h000;
    crtp_rate_s rate_i = 5'h00;
    logic smp_ready_o, adc_start_o, adc_valid_o, dac_trig_o, pwm_o;
    logic [7:0] adc_data_o, adc_pin;
    logic [15:0] duty;
    int errors = 0;
    int n_checks = 0;
    int pa, pd, k;
    crtp_row_s rows[7] = '{'{0, 0, 32, 40}, '{1, 0, 16, 40}, '{1, 1, 16, 20},
        '{2, 2, 12, 16}, '{3, 2, 8, 16}, '{4, 3, 4, 8}, '{7, 3, 4, 8}};
    int dv[8] = '{0, 1, 100, 512, 700, 900, 1000, 1023};

    // Short divisors keep every period within a few dozen cycles
    localparam crtp_cnt_t SIM_DAC0 = 16'h0028;
    localparam crtp_cnt_t SIM_DAC1 = 16'h0014;
    localparam crtp_cnt_t SIM_DAC2 = 16'h0010;
    localparam crtp_cnt_t SIM_DAC3 = 16'h0008;
    localparam crtp_cnt_t SIM_ADC0 = 16'h0020;
    localparam crtp_cnt_t SIM_ADC1 = 16'h0010;
    localparam crtp_cnt_t SIM_ADC2 = 16'h000C;
    localparam crtp_cnt_t SIM_ADC3 = 16'h0008;
    localparam crtp_cnt_t SIM_ADC4 = 16'h0004;

    always #5 clk_i = ~clk_i;

    crtp_top #(.DAC_DIV0(SIM_DAC0), .DAC_DIV1(SIM_DAC1), .DAC_DIV2(SIM_DAC2),
        .DAC_DIV3(SIM_DAC3), .ADC_DIV0(SIM_ADC0), .ADC_DIV1(SIM_ADC1),
        .ADC_DIV2(SIM_ADC2), .ADC_DIV3(SIM_ADC3), .ADC_DIV4(SIM_ADC4)) u_crtp_top (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .rate_i(rate_i),
        .smp_valid_i(smp_valid_i), .smp_ready_o(smp_ready_o), .smp_data_i(smp_data_i),
        .adc_pin_i(adc_pin), .adc_start_o(adc_start_o), .adc_valid_o(adc_valid_o),
        .adc_data_o(adc_data_o), .dac_trig_o(dac_trig_o), .pwm_o(pwm_o));

    crtp_ana_model u_crtp_ana_model (.clk_i(clk_i), .rst_i(rst_i),
        .adc_start_i(adc_start_o), .dac_trig_i(dac_trig_o), .pwm_i(pwm_o),
        .adc_pin_o(adc_pin), .duty_o(duty));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic step();
        @(posedge clk_i);
        #1;
    endtask

    // Period between two output ticks, bounded
    task automatic meas_dac(output int p);
        p = 0;
        while (dac_trig_o !== 1'b1 && p < 200) begin step(); p++; end
        p = 0;
        do begin step(); p++; end while (dac_trig_o !== 1'b1 && p < 200);
    endtask

    // Captured code settles for periods of 4 or more; only periods of 8 or more are checked
    task automatic meas_adc(output int p, input int exp);
        p = 0;
        while (adc_start_o !== 1'b1 && p < 200) begin step(); p++; end
        p = 0;
        do begin step(); p++; end while (adc_start_o !== 1'b1 && p < 200);
        check("adc_valid", adc_valid_o, 1'b1);
        if (exp >= 8) check("adc_data", adc_data_o, adc_pin);
    endtask

    function automatic int hi_of(input int d);
        return (d * 40) >> 10;
    endfunction

    task automatic complete_run();
        $display("Checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #500_000;
        errors++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        #1 rst_i = 1'b0;
        foreach (rows[i]) begin
            rate_i = {rows[i].a, rows[i].d};
            fork
                meas_dac(pd);
                meas_adc(pa, rows[i].ap);
            join
            check("dac_period", pd, rows[i].dp);
            check("adc_period", pa, rows[i].ap);
        end
        // Frozen clock enable gives no ticks
        // Let both pulses drop first: a pulse frozen high would count as ticks
        while (dac_trig_o !== 1'b0 || adc_start_o !== 1'b0) step();
        ce_i = 1'b0;
        pd = 0;
        repeat (60) begin step(); pd += dac_trig_o + adc_start_o; end
        check("ce_freeze", pd, 0);
        ce_i = 1'b1;
        // Second reset mid-run, then fill the FIFO before the first wrap
        rate_i = 5'h00;
        rst_i = 1'b1;
        step();
        check("rst_ready", smp_ready_o, 1'b1);
        check("rst_pwm", pwm_o, 1'b0);
        check("rst_ticks", {dac_trig_o, adc_start_o, adc_data_o}, 10'h000);
        rst_i = 1'b0;
        k = 0;
        smp_valid_i = 1'b1;
        smp_data_i = 10'(dv[0]);
        while (k < 12 && smp_ready_o === 1'b1) begin
            check("pwm_before_sample", pwm_o, 1'b0);
            step();
            k++;
            smp_data_i = 10'(dv[k % 8]);
        end
        smp_valid_i = 1'b0;
        check("fifo_words", k, 8);
        meas_dac(pd);
        for (int j = 0; j < 8; j++) begin
            meas_dac(pd);
            check("duty", duty, hi_of(dv[j]));
        end
        check("fifo_drained", smp_ready_o, 1'b1);
        meas_dac(pd);
        check("duty_repeat", duty, hi_of(dv[7]));
        complete_run();
    end
endmodule
`default_nettype wire
